// ===== design/ldcr_pkg.sv
package ldcr_pkg;

   // Word geometry
   localparam int unsigned WORD_W = 16;
   localparam logic [15:0] SETUP_RST = 16'h0000;
   localparam int unsigned CNT_W = 5;

   // Latch key edge counts
   localparam logic [4:0] KEY_WRITE = 5'h07;
   localparam logic [4:0] KEY_READ = 5'h08;
   localparam logic [4:0] CNT_MAX = 5'h1F;

   // Field positions
   localparam int unsigned GAIN_LSB = 0;
   localparam int unsigned GAIN_W = 6;
   localparam int unsigned RANGE_BIT = 6;
   localparam int unsigned FMODE_BIT = 7;
   localparam int unsigned SHORT_LSB = 8;
   localparam int unsigned APOFF_BIT = 10;
   localparam int unsigned EDGE_LSB = 11;
   localparam int unsigned SDO_SYNC_BIT = 13;
   localparam int unsigned NOSTAG_BIT = 14;
   localparam int unsigned DEPTH_BIT = 15;

   // Decoded settings handed to the core
   typedef struct packed {
      logic [5:0] gain;
      logic high_range;
      logic fault_reserved;
      logic [1:0] short_thr;
      logic auto_off;
      logic [1:0] edge_time;
      logic sdo_falling;
      logic stagger_on;
      logic depth12;
   } ldcr_setup_t;

   // Link-domain state
   typedef struct packed {
      logic [15:0] shift;
      logic [4:0] cnt;
      logic le_q;
      logic wr_tgl;
      logic [15:0] wr_word;
      logic [15:0] rd_shift;
      logic sdo_rise;
   } ldcr_link_t;

   // Core-domain state
   typedef struct packed {
      logic [2:0] tsync;
      logic [15:0] setup;
   } ldcr_core_t;

endpackage : ldcr_pkg

// ===== design/ldcr_sdo_fall.sv
`timescale 1ns/10ps
`default_nettype none
// Falling-edge retimer for the serial output
module ldcr_sdo_fall (
   // Link side
   input wire logic sclk_i,
   input wire logic rst_n_i,
   input wire logic d_i,
   // Retimed bit
   output logic q_o
);
   // Capture on falling shift clock edge
   always_ff @(negedge sclk_i)
   begin
      if (!rst_n_i)
      begin
         q_o <= 1'b0;
      end
      else
      begin
         q_o <= d_i;
      end
   end
endmodule : ldcr_sdo_fall
`default_nettype wire

// ===== design/ldcr_top.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] Whole setup word clears to zero on reset.
// [R2] Only a complete 16-bit word, bit 15 first shifted, updates the setup.
// [R3] Bits 5..0 give the 64-step gain code.
// [R4] Bit 6 picks low (0) or high (1) current range.
// [R5] Bit 7 selects fault-check mode; one is reserved.
// [R6] Bits 12..11 pick output edge time.
// [R7] Bit 13 set retimes serial output onto falling shift clock edge.
// [R8] Bit 14 clear staggers channels by 10 ns each.
// [R9] Bit 15 picks 16-bit (0) or 12-bit (1) grayscale depth.
// [R10] Bits 9..8 pick the shorted-LED threshold.
// [R11] Bit 10 enables automatic idle power-down.
// [R12] Seven clock edges with latch high write; eight read back.
// [R13] Serial input sampled on each rising shift clock edge.
module ldcr_top (
   // Core clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Serial link
   input wire logic sclk_i,
   input wire logic serial_in_pin_i,
   input wire logic latch_strobe_i,
   output logic serial_out_pin_o,
   // Decoded configuration
   output ldcr_pkg::ldcr_setup_t setup_o,
   output logic [15:0] setup_word_o
);
   ldcr_pkg::ldcr_link_t lk_r;
   ldcr_pkg::ldcr_link_t lk_nxt;
   ldcr_pkg::ldcr_core_t cr_r;
   ldcr_pkg::ldcr_core_t cr_nxt;
   logic [15:0] snap;
   logic sdo_fall;
   logic sdo_sel;
   logic [1:0] lrst_n_r;

   // Two-stage reset synchroniser for the link domain
   always_ff @(posedge sclk_i)
   begin
      lrst_n_r <= {lrst_n_r[0], rst_n_i};
   end

   // Core copy of the word handed to the link for readback
   assign snap = cr_r.setup;

   // Link logic: shift, count keys, act on latch fall
   always_comb
   begin
      lk_nxt = lk_r;
      lk_nxt.le_q = latch_strobe_i;
      lk_nxt.shift = {lk_r.shift[14:0], serial_in_pin_i}; // [R13] [R2]
      lk_nxt.rd_shift = {lk_r.rd_shift[14:0], 1'b0};
      lk_nxt.sdo_rise = lk_r.rd_shift[15];
      if (latch_strobe_i)
      begin
         if (!lk_r.le_q)
         begin
            lk_nxt.cnt = 5'h01;
         end
         else if (lk_r.cnt != ldcr_pkg::CNT_MAX)
         begin
            lk_nxt.cnt = lk_r.cnt + 5'h01;
         end
      end
      else if (lk_r.le_q)
      begin
         // Key decided by edges counted while latch was high
         if (lk_r.cnt == ldcr_pkg::KEY_WRITE) // [R12]
         begin
            lk_nxt.wr_word = lk_r.shift; // [R2]
            lk_nxt.wr_tgl = ~lk_r.wr_tgl;
         end
         else if (lk_r.cnt == ldcr_pkg::KEY_READ) // [R12]
         begin
            lk_nxt.rd_shift = snap;
         end
         lk_nxt.cnt = '0;
      end
   end

   // Link registers on rising shift clock
   always_ff @(posedge sclk_i)
   begin
      if (!lrst_n_r[1])
      begin
         lk_r <= '0;
      end
      else
      begin
         lk_r <= lk_nxt;
      end
   end

   // Optional falling-edge retiming of serial output
   ldcr_sdo_fall u_fall (
      .sclk_i(sclk_i),
      .rst_n_i(lrst_n_r[1]),
      .d_i(lk_r.rd_shift[15]),
      .q_o(sdo_fall)
   );
   assign sdo_sel = cr_r.setup[ldcr_pkg::SDO_SYNC_BIT]; // [R7]
   always_comb
   begin
      serial_out_pin_o = sdo_sel ? sdo_fall : lk_r.rd_shift[15]; // [R7]
   end

   // Core: synchronise write toggle, then take the word
   always_comb
   begin
      cr_nxt = cr_r;
      cr_nxt.tsync = {cr_r.tsync[1:0], lk_r.wr_tgl};
      if (cr_r.tsync[2] != cr_r.tsync[1])
      begin
         cr_nxt.setup = lk_r.wr_word; // [R2] stable since toggle
      end
   end

   // Core registers
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         cr_r <= '0;
         cr_r.setup <= ldcr_pkg::SETUP_RST; // [R1]
      end
      else
      begin
         cr_r <= cr_nxt;
      end
   end

   // Field decode
   always_comb
   begin
      setup_word_o = cr_r.setup;
      setup_o.gain = cr_r.setup[ldcr_pkg::GAIN_LSB +: ldcr_pkg::GAIN_W]; // [R3]
      setup_o.high_range = cr_r.setup[ldcr_pkg::RANGE_BIT]; // [R4]
      setup_o.fault_reserved = cr_r.setup[ldcr_pkg::FMODE_BIT]; // [R5]
      setup_o.short_thr = cr_r.setup[ldcr_pkg::SHORT_LSB +: 2]; // [R10]
      setup_o.auto_off = cr_r.setup[ldcr_pkg::APOFF_BIT]; // [R11]
      setup_o.edge_time = cr_r.setup[ldcr_pkg::EDGE_LSB +: 2]; // [R6]
      setup_o.sdo_falling = cr_r.setup[ldcr_pkg::SDO_SYNC_BIT]; // [R7]
      setup_o.stagger_on = ~cr_r.setup[ldcr_pkg::NOSTAG_BIT]; // [R8]
      setup_o.depth12 = cr_r.setup[ldcr_pkg::DEPTH_BIT]; // [R9]
   end

   // Checks in core domain
   chk_reset_clear: assert property (@(posedge mclk_i) !rst_n_i |=> cr_r.setup == 16'h0000) // [R1]
      else $error("setup not cleared by reset");
   chk_toggle_take: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (cr_r.tsync[2] != cr_r.tsync[1]) |=> cr_r.setup == $past(lk_r.wr_word)) // [R2]
      else $error("written word not taken");
   chk_hold_word: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (cr_r.tsync[2] == cr_r.tsync[1]) |=> $stable(cr_r.setup)) // [R12]
      else $error("setup changed without write");
   chk_gain_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      setup_o.gain == setup_word_o[5:0] && setup_o.high_range == setup_word_o[6]) // [R3]
      else $error("gain or range decode wrong");
   chk_stagger_inv: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      setup_o.stagger_on != setup_word_o[14]) // [R8]
      else $error("stagger decode wrong");
   chk_fmode_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      setup_o.fault_reserved == setup_word_o[7]) // [R5]
      else $error("fault mode decode wrong");
   chk_edge_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      setup_o.edge_time == setup_word_o[12:11]) // [R6]
      else $error("edge time decode wrong");
   chk_sdo_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      setup_o.sdo_falling == setup_word_o[13]) // [R7]
      else $error("serial out mode decode wrong");
   chk_depth_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      setup_o.depth12 == setup_word_o[15]) // [R9]
      else $error("depth decode wrong");
   chk_short_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      setup_o.short_thr == setup_word_o[9:8]) // [R10]
      else $error("short threshold decode wrong");
   chk_apoff_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      setup_o.auto_off == setup_word_o[10]) // [R11]
      else $error("auto off decode wrong");
   // Checks in link domain
   chk_write_key: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      (lk_r.le_q && !latch_strobe_i && lk_r.cnt == 5'h07) |=> lk_r.wr_tgl != $past(lk_r.wr_tgl)) // [R12]
      else $error("write key ignored");
   chk_read_load: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      (lk_r.le_q && !latch_strobe_i && lk_r.cnt == 5'h08) |=> lk_r.rd_shift == $past(snap)) // [R12]
      else $error("read key did not load");
   chk_sample_in: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      1'b1 |=> lk_r.shift[0] == $past(serial_in_pin_i)) // [R13]
      else $error("input not sampled");
   chk_sdo_rise: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      !sdo_sel |-> serial_out_pin_o == lk_r.rd_shift[15]) // [R7]
      else $error("serial out not direct");
   chk_sdo_fall: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      sdo_sel |-> serial_out_pin_o == lk_r.rd_shift[15]) // [R7]
      else $error("retimed serial out wrong");
   chk_other_keys: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      (lk_r.le_q && !latch_strobe_i && lk_r.cnt != 5'h07) |=> $stable(lk_r.wr_tgl)) // [R12]
      else $error("write without write key");
   chk_count_start: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      (latch_strobe_i && !lk_r.le_q) |=> lk_r.cnt == 5'h01) // [R12]
      else $error("key count did not start");
   chk_count_clear: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      (!latch_strobe_i && lk_r.le_q) |=> lk_r.cnt == 5'h00) // [R12]
      else $error("key count not cleared");
   chk_count_sat: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      (latch_strobe_i && lk_r.le_q && lk_r.cnt == 5'h1F) |=> lk_r.cnt == 5'h1F) // [R12]
      else $error("key count wrapped");
   chk_shift_chain: assert property (@(posedge sclk_i) disable iff (!lrst_n_r[1])
      1'b1 |=> lk_r.shift[15:1] == $past(lk_r.shift[14:0])) // [R2]
      else $error("shift chain broken");
endmodule : ldcr_top
`default_nettype wire

// ===== dv/ldcr_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host model on the four-wire link
module ldcr_host (
   // Link toward the device
   output logic sclk_o,
   output logic sdi_o,
   output logic le_o,
   input wire logic sdo_i
);
   logic s;
   // Idle: clock still, latch pulled low
   initial
   begin
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      le_o = 1'b0;
   end
   // One shift period, data set well before the rise
   task automatic tick(input logic d, input logic l);
      sdi_o = d;
      le_o = l;
      #39;
      s = sdo_i;
      #1 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
   endtask : tick
   // Whole word MSB first, key under latch, then readout
   task automatic xfer(input logic [15:0] w, input int key, output logic [15:0] rd);
      for (int k = 0; k < 33; k++)
      begin
         tick(k < 16 ? w[15-k] : ~w[0], k < 16 && k >= 16 - key);
         if (k > 16)
            rd[32-k] = s;
      end
   endtask : xfer
endmodule : ldcr_host
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the setup word
module tb_top;
   logic mclk_i;
   logic rst_n_i = 1'b0;
   logic sclk, serial_in_pin, le, sdo;
   ldcr_pkg::ldcr_setup_t setup;
   logic [15:0] word, rd, cur;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   // Bit 7 kept clear in every written word
   logic [15:0] tbl [6] = '{16'h5A5A, 16'hA525, 16'hFF7F, 16'h0800, 16'h1000, 16'h2001};

   ldcr_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .serial_in_pin_i(serial_in_pin),
      .latch_strobe_i(le), .serial_out_pin_o(sdo), .setup_o(setup), .setup_word_o(word));
   ldcr_host host (.sclk_o(sclk), .sdi_o(serial_in_pin), .le_o(le), .sdo_i(sdo));

   // Core clock
   initial
   begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   // Hang guard
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         stop_test();
      end
   end

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   // Expected decoded fields
   function automatic logic [15:0] dec(input logic [15:0] w);
      ldcr_pkg::ldcr_setup_t e;
      e = '{w[5:0], w[6], w[7], w[9:8], w[10], w[12:11], w[13], ~w[14], w[15]};
      return e;
   endfunction : dec

   // Reset with link edges inside it
   task automatic do_reset();
      @(negedge mclk_i);
      rst_n_i = 1'b0;
      repeat (8) @(negedge mclk_i);
      repeat (4) host.tick(1'b0, 1'b0);
      @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (3) host.tick(1'b0, 1'b0);
      cur = 16'h0000;
      check("rst word", word, 16'h0000);
   endtask : do_reset

   // One frame; only key 7 may change the word
   task automatic frame(input logic [15:0] w, input int key);
      host.xfer(w, key, rd);
      @(negedge mclk_i);
      if (key == 7)
         cur = w;
      check("word", word, cur);
      check("fields", setup, dec(cur));
   endtask : frame

   task automatic stop_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // Main sequence
   initial
   begin
      #1.3;
      do_reset();
      frame(16'hFFFF, 8);
      check("rst read", rd, 16'h0000);
      foreach (tbl[i])
      begin
         frame(tbl[i], 7);
         frame(~tbl[i], 8);
         check("read", rd, tbl[i]);
      end
      frame(16'h1234, 6);
      frame(16'h4321, 9);
      frame(16'h8421, 7);
      do_reset();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
